// ==== hdl/dmx_consts.svh ====
// constants of the diagnostic digital multiplexer: offsets, fields, resets, codes
// Notes on behaviour
// - Output type 01b selects digital mode, in which the chosen source drives the pin.
// - In digital mode the analog buffer is high impedance, so only the digital buffer drives.
// - Select bits [6:4] are the group and [3:0] the channel, and groups 100b to 111b give 0.
// - Group 000b carries regulator undervoltage, the converter UV/OV pairs and io overvoltage.
// - Group 001b carries sync-out, system, PLL, sync-in and switching clocks, others give 0.
// - Group 010b channels 1 to 5 carry the primary buck signals, and channel 0 gives 0.
// - Group 010b channels 6 to 10 carry the same five signals of the secondary buck.
// - Group 010b channels 11 to 15 carry boost signals, group 011b 1 to 3 the warnings.
// - With the output enable bit clear the pin is high impedance whatever the mode and select.
// - Output type 10b selects analog mode, in which the digital buffer is high impedance.
`ifndef DMX_CONSTS_SVH
`define DMX_CONSTS_SVH

// register byte offsets
`define DMX_OFS_CTRL      12'h000
`define DMX_OFS_SEL       12'h004
`define DMX_OFS_STAT      12'h008

// control register fields
`define DMX_CTRL_TYPE_LSB 0
`define DMX_CTRL_TYPE_MSB 1
`define DMX_CTRL_EN_BIT   2
`define DMX_CTRL_RST      3'h0

// source select fields
`define DMX_SEL_CH_LSB    0
`define DMX_SEL_CH_MSB    3
`define DMX_SEL_GRP_LSB   4
`define DMX_SEL_GRP_MSB   6
`define DMX_SEL_MSB       7
`define DMX_SEL_RST       8'h00

// status register fields
`define DMX_STAT_PIN_BIT  0
`define DMX_STAT_DOE_BIT  1
`define DMX_STAT_AEN_BIT  2
`define DMX_STAT_IOOV_BIT 3

// output type codes
`define DMX_TYPE_OUTCTL   2'h0
`define DMX_TYPE_DIG      2'h1
`define DMX_TYPE_ANA      2'h2
`define DMX_TYPE_ICON     2'h3

// timing: select register, source register, pin register
`define DMX_PIN_LATENCY   2

`endif

// ==== hdl/dmx_pkg.sv ====
// types shared by the diagnostic digital multiplexer
package dmx_pkg;

	// one-hot output mode after decode
	typedef enum logic [3:0] {
		DMX_MODE_OUTCTL = 4'b0001,
		DMX_MODE_DIG    = 4'b0010,
		DMX_MODE_ANA    = 4'b0100,
		DMX_MODE_ICON   = 4'b1000
	} dmx_mode_e;

	// internal digital sources offered to the multiplexer
	typedef struct packed {
		logic int_reg_uv;
		logic prim_uv;
		logic prim_ov;
		logic sec_uv;
		logic sec_ov;
		logic bst_uv;
		logic bst_ov;
		logic io_ov;
		logic sync_out_clk;
		logic sys_clk;
		logic pll_clk;
		logic sync_in_clk;
		logic prim_sw_clk;
		logic sec_sw_clk;
		logic bst_sw_clk;
		logic prim_hs_ilim;
		logic prim_ls_ilim;
		logic prim_ls_sink_ilim;
		logic prim_ovp;
		logic prim_ot;
		logic sec_hs_ilim;
		logic sec_ls_ilim;
		logic sec_ls_sink_ilim;
		logic sec_ovp;
		logic sec_ot;
		logic bst_ls_ilim;
		logic bst_hs_ilim;
		logic bst_hs_sink_ilim;
		logic bst_ovp;
		logic bst_ot;
		logic prim_ot_warn;
		logic sec_ot_warn;
		logic bst_ot_warn;
	} dmx_src_s;

	// diagnostic control register content
	typedef struct packed {
		logic       en;
		logic [1:0] otype;
	} dmx_ctrl_s;

	// diagnostic source select register content
	typedef struct packed {
		logic       spare;
		logic [2:0] grp;
		logic [3:0] ch;
	} dmx_sel_s;

endpackage

// ==== hdl/dmx_src_mux.sv ====
// source table and registered selection of one internal digital signal
`timescale 1ns/100ps
`include "dmx_consts.svh"
module dmx_src_mux #(
	parameter int GRP_W = 3, // group code width
	parameter int CH_W  = 4  // channel code width
) (
	input  wire logic                     pclk,    // system clock
	input  wire logic                     presetn, // async reset, active low
	input  wire logic [GRP_W+CH_W-1:0]    idx,     // group and channel
	input  wire dmx_pkg::dmx_src_s        src,     // internal sources
	output logic                          bit_r    // selected source, registered
);
	localparam int N = 1 << (GRP_W + CH_W);

	// the table below is laid out for exactly a 3-bit group and 4-bit channel
	if (GRP_W != 3 || CH_W != 4) begin : g_bad_width
		$error("dmx_src_mux serves only a 3-bit group and 4-bit channel");
	end

	// one table entry per group and channel code
	function automatic logic pick(input logic [6:0] i, input dmx_pkg::dmx_src_s s);
		case (i)
			7'h01: pick = s.int_reg_uv;
			7'h07: pick = s.prim_uv;
			7'h08: pick = s.prim_ov;
			7'h09: pick = s.sec_uv;
			7'h0a: pick = s.sec_ov;
			7'h0b: pick = s.bst_uv;
			7'h0c: pick = s.bst_ov;
			7'h0f: pick = s.io_ov;
			7'h10: pick = s.sync_out_clk;
			7'h11: pick = s.sys_clk;
			7'h12: pick = s.pll_clk;
			7'h13: pick = s.sync_in_clk;
			7'h14: pick = s.prim_sw_clk;
			7'h15: pick = s.sec_sw_clk;
			7'h17: pick = s.bst_sw_clk;
			7'h21: pick = s.prim_hs_ilim;
			7'h22: pick = s.prim_ls_ilim;
			7'h23: pick = s.prim_ls_sink_ilim;
			7'h24: pick = s.prim_ovp;
			7'h25: pick = s.prim_ot;
			7'h26: pick = s.sec_hs_ilim;
			7'h27: pick = s.sec_ls_ilim;
			7'h28: pick = s.sec_ls_sink_ilim;
			7'h29: pick = s.sec_ovp;
			7'h2a: pick = s.sec_ot;
			7'h2b: pick = s.bst_ls_ilim;
			7'h2c: pick = s.bst_hs_ilim;
			7'h2d: pick = s.bst_hs_sink_ilim;
			7'h2e: pick = s.bst_ovp;
			7'h2f: pick = s.bst_ot;
			7'h31: pick = s.prim_ot_warn;
			7'h32: pick = s.sec_ot_warn;
			7'h33: pick = s.bst_ot_warn;
			default: pick = 1'b0;
		endcase
	endfunction

	logic [N-1:0] tbl;

	// flatten the sources into one vector indexed by the select code
	for (genvar i = 0; i < N; i++) begin : g_ent
		assign tbl[i] = pick(7'(i), src);
	end

	// registering the pick keeps decode glitches off the pin
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			bit_r <= 1'b0;
		else
			bit_r <= tbl[idx];
	end
endmodule

// ==== hdl/dmx_diag_mux.sv ====
// diagnostic output multiplexer top: apb registers, mode decode and pin drivers
//
// Register access over APB and the register addresses are this design's own decisions.
`timescale 1ns/100ps
`include "dmx_consts.svh"
module dmx_diag_mux #(
	parameter int ADDR_W = 12 // apb address width
) (
	input  wire logic              pclk,           // system clock, 25 MHz
	input  wire logic              presetn,        // async reset, active low
	input  wire logic [ADDR_W-1:0] paddr,          // apb byte address
	input  wire logic              psel,           // apb select
	input  wire logic              penable,        // apb access phase
	input  wire logic              pwrite,         // apb direction, high writes
	input  wire logic [31:0]       pwdata,         // apb write data
	input  wire logic [3:0]        pstrb,          // apb write byte strobes
	output logic [31:0]            prdata,         // apb read data
	output logic                   pready,         // apb ready
	output logic                   pslverr,        // apb error, unmapped address
	input  wire dmx_pkg::dmx_src_s src,            // internal digital sources
	output logic                   diag_pin_out,   // digital buffer data
	output logic                   diag_pin_oe,    // digital buffer enable
	output logic                   ana_buf_en,     // analog buffer enable
	output logic [7:0]             ana_chan_sel    // analog channel select
);

	// the register map needs at least the status offset
	if (ADDR_W < 4) begin : g_bad_addr
		$error("dmx_diag_mux needs an address of at least 4 bits");
	end

	// register state
	dmx_pkg::dmx_ctrl_s ctrl_r;
	dmx_pkg::dmx_ctrl_s ctrl_nxt;
	dmx_pkg::dmx_sel_s  sel_r;
	dmx_pkg::dmx_sel_s  sel_nxt;
	logic [31:0]        prdata_r;
	logic               pready_r;
	logic               pslverr_r;

	// pin side state
	logic               src_bit;
	logic               pin_r;
	logic               oe_r;
	logic               aen_r;
	logic [7:0]         achan_r;
	dmx_pkg::dmx_mode_e mode;

	// apb phase decode
	wire setup_ph = psel && !penable;
	wire access_ph = psel && penable && pready_r;
	wire wr_acc = access_ph && pwrite && pstrb[0];

	// address decode, word aligned
	wire [11:0] addr12 = 12'(paddr);
	wire hit_ctrl = (addr12 == `DMX_OFS_CTRL);
	wire hit_sel = (addr12 == `DMX_OFS_SEL);
	wire hit_stat = (addr12 == `DMX_OFS_STAT);
	wire hit_any = hit_ctrl || hit_sel || hit_stat;

	// status is read only, writes to it are quietly ignored
	wire wr_ctrl = wr_acc && hit_ctrl;
	wire wr_sel = wr_acc && hit_sel;

	// field extraction from the write data
	wire [1:0] wd_type = pwdata[`DMX_CTRL_TYPE_MSB:`DMX_CTRL_TYPE_LSB];
	wire wd_en = pwdata[`DMX_CTRL_EN_BIT];
	wire [7:0] wd_sel = pwdata[`DMX_SEL_MSB:0];

	// next register values
	always_comb begin
		ctrl_nxt = ctrl_r;
		sel_nxt = sel_r;
		if (wr_ctrl) begin
			ctrl_nxt.otype = wd_type;
			ctrl_nxt.en = wd_en;
		end
		if (wr_sel) begin
			sel_nxt = wd_sel;
		end
	end

	// read images, reserved bits zero
	wire [31:0] rd_ctrl = {29'h0, ctrl_r.en, ctrl_r.otype};
	wire [31:0] rd_sel = {24'h0, sel_r};
	wire [31:0] rd_stat = {28'h0, src.io_ov, aen_r, oe_r, pin_r};

	// read select
	wire [31:0] rd_mux = hit_ctrl ? rd_ctrl :
	                     hit_sel  ? rd_sel  :
	                     hit_stat ? rd_stat : 32'h0;

	// control and select registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r <= `DMX_CTRL_RST;
			sel_r <= `DMX_SEL_RST;
		end else begin
			ctrl_r <= ctrl_nxt;
			sel_r <= sel_nxt;
		end
	end

	// apb answer: ready in the first access cycle, data caught at setup
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_r <= 1'b0;
			prdata_r <= 32'h0;
			pslverr_r <= 1'b0;
		end else begin
			pready_r <= setup_ph;
			if (setup_ph) begin
				prdata_r <= pwrite ? 32'h0 : rd_mux;
				pslverr_r <= !hit_any;
			end
		end
	end

	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;

	// decode the output type into a one-hot mode
	always_comb begin
		case (ctrl_r.otype)
			`DMX_TYPE_OUTCTL: mode = dmx_pkg::DMX_MODE_OUTCTL;
			`DMX_TYPE_DIG:    mode = dmx_pkg::DMX_MODE_DIG;
			`DMX_TYPE_ANA:    mode = dmx_pkg::DMX_MODE_ANA;
			`DMX_TYPE_ICON:   mode = dmx_pkg::DMX_MODE_ICON;
			default:          mode = dmx_pkg::DMX_MODE_OUTCTL;
		endcase
	end

	// registered source pick from the group and channel fields
	dmx_src_mux #(
		.GRP_W (3),
		.CH_W  (4)
	) u_src (
		.pclk    (pclk),
		.presetn (presetn),
		.idx     ({sel_r.grp, sel_r.ch}),
		.src     (src),
		.bit_r   (src_bit)
	);

	// an io overvoltage cuts the buffer supply, so both buffers drop
	wire buf_ok = ctrl_r.en && !src.io_ov;
	wire dig_on = buf_ok && (mode == dmx_pkg::DMX_MODE_DIG);
	wire ana_on = buf_ok && (mode == dmx_pkg::DMX_MODE_ANA);

	// pin drivers; clocks slower than half of pclk come out sampled, so jittered
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_r <= 1'b0;
			oe_r <= 1'b0;
			aen_r <= 1'b0;
			achan_r <= 8'h00;
		end else begin
			pin_r <= dig_on && src_bit;
			oe_r <= dig_on;
			aen_r <= ana_on;
			achan_r <= sel_r;
		end
	end

	assign diag_pin_out = pin_r;
	assign diag_pin_oe = oe_r;
	assign ana_buf_en = aen_r;
	assign ana_chan_sel = achan_r;

endmodule

// ==== test/dmx_mcu_pin.sv ====
// model of the microcontroller input pin watching the diagnostic output
`timescale 1ns/100ps
module dmx_mcu_pin (
	input  wire logic pclk,  // sampling clock
	input  wire logic pin,   // digital buffer data
	input  wire logic oe,    // digital buffer enable
	output logic      level  // level seen by the input
);
	// no pull on the line: a released pin toggles, so a stale value is never trusted
	logic float_r = 1'b0;
	always @(posedge pclk) begin
		float_r <= ~float_r;
	end
	assign level = oe ? pin : float_r;
endmodule

// ==== test/dmx_diag_mux_assertions.sv ====
// concurrent checks on the diagnostic multiplexer top ports
`timescale 1ns/100ps
module dmx_diag_mux_assertions #(
	parameter int ADDR_W = 12 // apb address width
) (
	input wire logic              pclk,         // system clock
	input wire logic              presetn,      // async reset, active low
	input wire logic [ADDR_W-1:0] paddr,        // apb address
	input wire logic              psel,         // apb select
	input wire logic              penable,      // apb access phase
	input wire logic              pwrite,       // apb direction
	input wire logic [31:0]       pwdata,       // apb write data
	input wire logic [3:0]        pstrb,        // apb strobes
	input wire logic [31:0]       prdata,       // apb read data
	input wire logic              pready,       // apb ready
	input wire logic              pslverr,      // apb error
	input wire dmx_pkg::dmx_src_s src,          // internal sources
	input wire logic              diag_pin_out, // digital data
	input wire logic              diag_pin_oe,  // digital enable
	input wire logic              ana_buf_en,   // analog enable
	input wire logic [7:0]        ana_chan_sel  // analog select copy
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// completed writes; only strobe 0 carries the fields
	wire wr_done = psel && penable && pready && pwrite && pstrb[0];
	wire ctl_wr  = wr_done && paddr == ADDR_W'('h0);
	wire sel_wr  = wr_done && paddr == ADDR_W'('h4);
	wire dig_wr  = ctl_wr && pwdata[2:0] == 3'h5 && !src.io_ov;
	wire ana_wr  = ctl_wr && pwdata[2:0] == 3'h6 && !src.io_ov;

	pin_low_off_a: assert property (!diag_pin_oe |-> !diag_pin_out)
		else $error("pin data high while released");
	one_buffer_a: assert property (!(diag_pin_oe && ana_buf_en))
		else $error("both buffers enabled");
	dig_on_a: assert property (dig_wr |-> ##[2:3] diag_pin_oe)
		else $error("digital mode did not enable pin");
	ana_on_a: assert property (ana_wr |-> ##[2:3] ana_buf_en)
		else $error("analog mode did not enable buffer");
	en_off_a: assert property (ctl_wr && !pwdata[2] |-> ##3 !diag_pin_oe && !ana_buf_en)
		else $error("disabled output still driven");
	type_off_a: assert property (ctl_wr && pwdata[1:0] != 2'h1 |-> ##3 !diag_pin_oe)
		else $error("digital buffer on outside digital mode");
	rsv_group_a: assert property (sel_wr && pwdata[6] |-> ##3 !diag_pin_out)
		else $error("reserved group not low");
	rsv_chan0_a: assert property (sel_wr && pwdata[6:0] == 7'h00 |-> ##3 !diag_pin_out)
		else $error("reserved channel not low");
	chan_copy_a: assert property (sel_wr |-> ##3 ana_chan_sel == $past(pwdata[7:0], 3))
		else $error("select not applied in time");
	ready_next_a: assert property (psel && !penable |=> pready)
		else $error("ready missing after setup");
	ready_once_a: assert property (pready |=> !pready)
		else $error("ready held longer than one cycle");

	cover property (ctl_wr && pwdata[2:0] == 3'h5);
	cover property (sel_wr && pwdata[6]);
	cover property (pready && pslverr);
endmodule

bind dmx_diag_mux dmx_diag_mux_assertions #(.ADDR_W(ADDR_W)) i_chk (.pclk, .presetn, .paddr,
	.psel, .penable, .pwrite, .pwdata, .pstrb, .prdata, .pready, .pslverr, .src,
	.diag_pin_out, .diag_pin_oe, .ana_buf_en, .ana_chan_sel);

// ==== test/dmx_diag_mux_test.sv ====
// self-checking bench of the diagnostic digital multiplexer
`timescale 1ns/100ps
module dmx_diag_mux_test;
	logic              pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic              pin, oe, aen, lvl, err;
	logic [11:0]       paddr;
	logic [31:0]       pwdata, prdata, rd;
	logic [3:0]        pstrb;
	logic [7:0]        chan;
	logic [32:0]       lf = 33'h12688;
	dmx_pkg::dmx_src_s src;
	int                error_cnt = 0;
	int                cmp_count = 0;
	int                cyc = 0;

	dmx_diag_mux i_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .src(src),
		.diag_pin_out(pin), .diag_pin_oe(oe), .ana_buf_en(aen), .ana_chan_sel(chan));
	dmx_mcu_pin i_mcu (.pclk(pclk), .pin(pin), .oe(oe), .level(lvl));

	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end
	// hang guard, well above the roughly one thousand cycles the run needs
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			error_cnt++;
			report_and_stop();
		end
	end

	function logic [32:0] lfsr(logic [32:0] x);
		return {x[31:0], x[32] ^ x[19]};
	endfunction
	// expected source for a select code; unlisted codes give low
	function logic exp_bit(logic [6:0] s, dmx_pkg::dmx_src_s v);
		logic [32:0] b;
		int          c;
		b = v;
		c = s[3:0];
		case (s[6:4])
			3'h0: exp_bit = (c == 1) ? b[32] : (c >= 7 && c <= 12) ? b[38-c] : (c == 15) ? b[25] : 1'b0;
			3'h1: exp_bit = (c <= 5) ? b[24-c] : (c == 7) ? b[18] : 1'b0;
			3'h2: exp_bit = (c >= 1) ? b[18-c] : 1'b0;
			3'h3: exp_bit = (c >= 1 && c <= 3) ? b[3-c] : 1'b0;
			default: exp_bit = 1'b0;
		endcase
	endfunction

	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// one apb transfer; holds the request until pready is seen high
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	// pin side against control bits and select, from the current sources
	task pins(input logic [2:0] ctl, input logic [7:0] s);
		logic o;
		o = ctl[2] && ctl[1:0] == 2'h1 && !src.io_ov;
		chk("oe", oe, o);
		chk("ana", aen, ctl[2] && ctl[1:0] == 2'h2 && !src.io_ov);
		chk("pin", pin, o && exp_bit(s[6:0], src));
		chk("chan", chan, s);
		if (o) chk("mcu", lvl, exp_bit(s[6:0], src));
	endtask
	task report_and_stop();
		$display("compares %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask

	initial begin
		presetn = 1'b0;
		{psel, penable, pwrite, paddr, pwdata, src} = '0;
		pstrb = 4'hf;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		pins(3'h0, 8'h00);
		// reset reads, the fourth word is unmapped
		for (int a = 0; a < 16; a += 4) begin
			apb(1'b0, 12'(a), 32'h0);
			chk("rst_rd", rd, 32'h0);
			chk("err", err, a == 12);
		end
		apb(1'b1, 12'h010, 32'hff);
		chk("wr_err", err, 1'b1);
		$display("reset and map test done");
		// every group and channel code, spare bit clear, with random sources
		apb(1'b1, 12'h000, 32'h5);
		for (int i = 0; i < 128; i++) begin
			apb(1'b1, 12'h004, 32'(i));
			lf = lfsr(lf);
			src <= lf;
			repeat (4) @(posedge pclk);
			pins(3'h5, 8'(i));
		end
		$display("select sweep done");
		// all output types, enabled and disabled
		src.io_ov <= 1'b0;
		apb(1'b1, 12'h004, 32'h17);
		for (int c = 0; c < 8; c++) begin
			apb(1'b1, 12'h000, 32'(c));
			repeat (4) @(posedge pclk);
			pins(3'(c), 8'h17);
			apb(1'b0, 12'h000, 32'h0);
			chk("ctrl", rd, 32'(c));
			apb(1'b0, 12'h008, 32'h0);
			chk("stat", rd, {29'h0, c == 6, c == 5, c == 5 && src.bst_sw_clk});
		end
		$display("mode test done");
		// supply overvoltage drops the buffer, strobe-less write is ignored
		apb(1'b1, 12'h000, 32'h5);
		repeat (4) @(posedge pclk);
		src.io_ov <= 1'b1;
		repeat (4) @(posedge pclk);
		pins(3'h5, 8'h17);
		apb(1'b0, 12'h008, 32'h0);
		chk("stat", rd[3:0], 4'h8);
		pstrb <= 4'h0;
		apb(1'b1, 12'h004, 32'h33);
		pstrb <= 4'hf;
		apb(1'b0, 12'h004, 32'h0);
		chk("sel", rd, 32'h17);
		$display("overvoltage and strobe test done");
		// reset in mid-run clears the registers and releases the pin
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		pins(3'h0, 8'h00);
		apb(1'b0, 12'h004, 32'h0);
		chk("rst_sel", rd, 32'h0);
		apb(1'b0, 12'h000, 32'h0);
		chk("rst_ctrl", rd, 32'h0);
		$display("mid-run reset test done");
		report_and_stop();
	end
endmodule
